// file: core/nrt_map.vh
// Register offsets, field positions, reset values and timing constants of the protocol timer block.
`ifndef NRT_MAP_VH
`define NRT_MAP_VH
`define NRT_OFF_CTRL 12'h000
`define NRT_OFF_MRT 12'h004
`define NRT_OFF_NRT 12'h008
`define NRT_OFF_GPT 12'h00C
`define NRT_OFF_WUT 12'h010
`define NRT_OFF_CMD 12'h014
`define NRT_OFF_STAT 12'h018
`define NRT_OFF_FLAG 12'h01C
`define NRT_OFF_EVT 12'h020
// Control register fields.
`define NRT_C_OSC_EN 0
`define NRT_C_NRT_STEP 1
`define NRT_C_NRT_EMV 2
`define NRT_C_SQ_EN 3
`define NRT_C_P2P 4
`define NRT_C_LPTGT 5
`define NRT_C_WAKE_MODE 6
`define NRT_C_GPT_TRG_LO 7
`define NRT_C_GPT_TRG_HI 8
`define NRT_CTRL_W 9
`define NRT_CTRL_RST 9'h000
// General purpose timer trigger selection.
`define NRT_GTRG_NONE 2'h0
`define NRT_GTRG_SOF 2'h1
`define NRT_GTRG_EOF 2'h2
`define NRT_GTRG_FOFF 2'h3
// Command register bits, write one to issue.
`define NRT_K_CLEAR 0
`define NRT_K_MRT 1
`define NRT_K_NRT 2
`define NRT_K_GPT 3
`define NRT_K_WUT 4
// Status bits.
`define NRT_S_OSC_OK 0
`define NRT_S_MRT_RUN 1
`define NRT_S_NRT_RUN 2
`define NRT_S_GPT_RUN 3
`define NRT_S_WUT_RUN 4
`define NRT_S_RXWIN 5
// Flag bits, write one to clear.
`define NRT_F_OSC 0
`define NRT_F_NRE 1
`define NRT_F_GPE 2
`define NRT_F_WT 3
`define NRT_NFLAG 4
// Simulated event inputs from software, write one to pulse.
`define NRT_E_TXEND 0
`define NRT_E_SOF 1
`define NRT_E_EOF 2
`define NRT_E_FON 3
`define NRT_E_FOFF 4
`define NRT_E_BUSY 5
// Prescales in carrier periods per count; the wake-up prescale is in RC periods, the settle count in carrier edges.
`define NRT_MRT_DIV 16'h0040
`define NRT_MRT_LP_DIV 16'h0200
`define NRT_NRT_DIV_S 16'h0040
`define NRT_NRT_DIV_L 16'h1000
`define NRT_GPT_DIV 16'h0008
`define NRT_WUT_DIV 16'h0001
`define NRT_OSC_SETTLE 16'h0100
`define NRT_ZERO16 16'h0000
`define NRT_ONE16 16'h0001
`endif

// file: core/nrt_tmr.v
// One prescaled down-counting timer with start, stop and a one-cycle expiry pulse.
`timescale 1ns/1ps
module nrt_tmr (
   input wire pclk, // Clock.
   input wire presetn, // Asynchronous reset, active low.
   input wire tick, // Count enable, one per source clock period.
   input wire start, // Load and run, restarts a running timer.
   input wire stop, // Stop without expiry.
   input wire [15:0] div, // Ticks per count.
   input wire [15:0] load, // Counts to expiry.
   output reg run, // Timer running.
   output reg expire // One-cycle pulse at timeout.
);
`include "nrt_map.vh"
reg [15:0] pre;
reg [15:0] cnt;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      run <= 1'b0;
      expire <= 1'b0;
      pre <= 16'h0000;
      cnt <= 16'h0000;
   end else begin
      expire <= 1'b0;
      if (start) begin
         run <= (load != `NRT_ZERO16);
         cnt <= load;
         pre <= `NRT_ZERO16;
      end else if (stop) begin
         run <= 1'b0;
      end else if (run && tick) begin
         if (pre + `NRT_ONE16 >= div) begin
            pre <= `NRT_ZERO16;
            if (cnt == `NRT_ONE16) begin
               run <= 1'b0;
               expire <= 1'b1;
            end
            cnt <= cnt - `NRT_ONE16;
         end else begin
            pre <= pre + `NRT_ONE16;
         end
      end
   end
end
endmodule // nrt_tmr

// file: core/nrt_timers.v
// Protocol timers of an HF reader: mask-receive, no-response, general purpose and wake-up, with APB registers.
// Contract
// - Oscillator enable runs oscillator; stable sets readable flag and event.
// - Clear command stops all timers except wake-up timer and, in mode 1, no-response timer.
// - Transmit end starts no-response timer, and mask-receive timer outside peer mode.
// - Receive window held low while mask-receive timer runs.
// - Squelch forced on while mask timer runs if enabled; no expiry event.
// - Peer mode: peer field on starts mask-receive timer.
// - Low power target: command starts mask timer, 512 periods per count, then watch.
// - No-response step is 64 or 4096 carrier periods.
// - Mode 0: expiry before reply flags and drops window; reply stops timer.
// - Mode 1: expiry always flags, ignores clear, drops window only if idle.
// - No-response timeout has its own status flag.
// - Start command starts or restarts no-response timer.
// - Peer mode ignores no-response start command.
// - Peer mode: expiry before peer field on raises event.
// - General timer triggers on SOF, EOF or, in peer mode only, field off; expiry always flags.
// - Start command starts or restarts general purpose timer.
// - Wake-up start accepted outside wake mode; RC clocked; expiry sets flag.
// - Receiver state captured while window high; falling edge ends reception.
`timescale 1ns/1ps
module nrt_timers (
   input wire pclk, // APB clock.
   input wire presetn, // Asynchronous reset, active low.
   input wire psel, // APB select.
   input wire penable, // APB enable.
   input wire pwrite, // APB direction.
   input wire [11:0] paddr, // APB byte address.
   input wire [31:0] pwdata, // APB write data.
   output reg [31:0] prdata, // APB read data.
   output reg pready, // APB ready.
   output reg pslverr, // APB error on unmapped address.
   input wire fc_clk_in, // Carrier-rate clock from the crystal, async.
   input wire rc_clk_in, // Wake-up RC oscillator clock, async.
   input wire rx_data_in, // Receiver output, async.
   output reg rx_window, // Receive window enable.
   output reg squelch_on, // Squelch forced on.
   output reg osc_run, // Crystal oscillator enable.
   output reg rc_run, // RC oscillator enable.
   output reg irq_flag_any, // Any flag set, the oscillator flag included.
   output reg [3:0] rx_capture, // Receiver state held at reception end.
   output reg msg_start // Pulse: message start seen after low-power mask.
);
`include "nrt_map.vh"
reg [`NRT_CTRL_W-1:0] ctrl;
reg [15:0] mrt_cfg, nrt_cfg, gpt_cfg, wut_cfg;
reg [`NRT_NFLAG-1:0] flag;
reg [15:0] settle;
reg osc_ok;
reg [2:0] fc_s, rc_s, rx_s;
reg lp_watch, reply_busy, peer_on, rx_win_q;
reg [3:0] rx_cnt;
wire acc = psel && penable;
wire wr = acc && pwrite;
wire cmd_wr = wr && (paddr == `NRT_OFF_CMD);
wire evt_wr = wr && (paddr == `NRT_OFF_EVT);
wire k_clear = cmd_wr && pwdata[`NRT_K_CLEAR];
wire p2p = ctrl[`NRT_C_P2P];
wire lptgt = ctrl[`NRT_C_LPTGT];
wire emv = ctrl[`NRT_C_NRT_EMV];
wire [1:0] gtrg = ctrl[`NRT_C_GPT_TRG_HI:`NRT_C_GPT_TRG_LO];
wire e_txend = evt_wr && pwdata[`NRT_E_TXEND];
wire e_sof = evt_wr && pwdata[`NRT_E_SOF];
wire e_eof = evt_wr && pwdata[`NRT_E_EOF];
wire e_fon = evt_wr && pwdata[`NRT_E_FON];
wire e_foff = evt_wr && pwdata[`NRT_E_FOFF];
wire fc_tick = (fc_s[2] != fc_s[1]) && fc_s[2] && osc_run;
wire rc_tick = (rc_s[2] != rc_s[1]) && rc_s[2] && rc_run;
wire mrt_run, nrt_run, gpt_run, wut_run;
wire mrt_exp, nrt_exp, gpt_exp, wut_exp;
// Peer field on is the start of a reply in peer mode.
wire reply_start = p2p ? e_fon : e_sof;
wire mrt_start = (e_txend && !p2p) || (p2p && e_fon) || (lptgt && cmd_wr && pwdata[`NRT_K_MRT]);
wire nrt_cmd = cmd_wr && pwdata[`NRT_K_NRT] && !p2p;
wire nrt_start = e_txend || nrt_cmd;
wire nrt_stop = (k_clear && !emv) || (reply_start && !emv && nrt_run);
wire gpt_trig = (gtrg == `NRT_GTRG_SOF && e_sof) || (gtrg == `NRT_GTRG_EOF && e_eof) ||
   (gtrg == `NRT_GTRG_FOFF && p2p && e_foff);
wire gpt_start = gpt_trig || (cmd_wr && pwdata[`NRT_K_GPT]);
wire wut_start = cmd_wr && pwdata[`NRT_K_WUT] && !ctrl[`NRT_C_WAKE_MODE];
wire [15:0] mrt_div = lptgt ? `NRT_MRT_LP_DIV : `NRT_MRT_DIV;
wire [15:0] nrt_div = ctrl[`NRT_C_NRT_STEP] ? `NRT_NRT_DIV_L : `NRT_NRT_DIV_S;
// Timeout drops the window; in mode 1 only when no reply is in progress.
wire nrt_kill = nrt_exp && (!emv || !reply_busy);
wire [`NRT_NFLAG-1:0] set_v;
assign set_v[`NRT_F_OSC] = osc_run && !osc_ok && (settle == `NRT_OSC_SETTLE);
// Mode 0 timer is stopped by a reply, so any expiry means none came first.
assign set_v[`NRT_F_NRE] = nrt_exp;
assign set_v[`NRT_F_GPE] = gpt_exp;
assign set_v[`NRT_F_WT] = wut_exp;
nrt_tmr u_mrt (.pclk(pclk), .presetn(presetn), .tick(fc_tick), .start(mrt_start), .stop(k_clear),
   .div(mrt_div), .load(mrt_cfg), .run(mrt_run), .expire(mrt_exp));
nrt_tmr u_nrt (.pclk(pclk), .presetn(presetn), .tick(fc_tick), .start(nrt_start), .stop(nrt_stop),
   .div(nrt_div), .load(nrt_cfg), .run(nrt_run), .expire(nrt_exp));
nrt_tmr u_gpt (.pclk(pclk), .presetn(presetn), .tick(fc_tick), .start(gpt_start), .stop(k_clear),
   .div(`NRT_GPT_DIV), .load(gpt_cfg), .run(gpt_run), .expire(gpt_exp));
nrt_tmr u_wut (.pclk(pclk), .presetn(presetn), .tick(rc_tick), .start(wut_start), .stop(1'b0),
   .div(`NRT_WUT_DIV), .load(wut_cfg), .run(wut_run), .expire(wut_exp));
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      fc_s <= 3'h0;
      rc_s <= 3'h0;
      rx_s <= 3'h0;
   end else begin
      fc_s <= {fc_s[1:0], fc_clk_in};
      rc_s <= {rc_s[1:0], rc_clk_in};
      rx_s <= {rx_s[1:0], rx_data_in};
   end
end
// Oscillator settling is modelled by counting carrier edges after enable.
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      settle <= 16'h0000;
      osc_ok <= 1'b0;
   end else if (!osc_run) begin
      settle <= `NRT_ZERO16;
      osc_ok <= 1'b0;
   end else if (!osc_ok) begin
      if (settle == `NRT_OSC_SETTLE)
         osc_ok <= 1'b1;
      else if (fc_s[2] != fc_s[1])
         settle <= settle + `NRT_ONE16;
   end
end
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ctrl <= `NRT_CTRL_RST;
      mrt_cfg <= 16'h0000;
      nrt_cfg <= 16'h0000;
      gpt_cfg <= 16'h0000;
      wut_cfg <= 16'h0000;
      flag <= 4'h0;
   end else begin
      if (wr && paddr == `NRT_OFF_CTRL)
         ctrl <= pwdata[`NRT_CTRL_W-1:0];
      // The host keeps configuration stable while a timer runs; no interlock here.
      if (wr && paddr == `NRT_OFF_MRT)
         mrt_cfg <= pwdata[15:0];
      if (wr && paddr == `NRT_OFF_NRT)
         nrt_cfg <= pwdata[15:0];
      if (wr && paddr == `NRT_OFF_GPT)
         gpt_cfg <= pwdata[15:0];
      if (wr && paddr == `NRT_OFF_WUT)
         wut_cfg <= pwdata[15:0];
      // A set in the same cycle as a clear wins.
      if (wr && paddr == `NRT_OFF_FLAG)
         flag <= (flag & ~pwdata[`NRT_NFLAG-1:0]) | set_v;
      else
         flag <= flag | set_v;
   end
end
// Window, squelch, reply tracking and reception capture.
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      rx_window <= 1'b0;
      squelch_on <= 1'b0;
      osc_run <= 1'b0;
      rc_run <= 1'b0;
      irq_flag_any <= 1'b0;
      rx_capture <= 4'h0;
      msg_start <= 1'b0;
      lp_watch <= 1'b0;
      reply_busy <= 1'b0;
      peer_on <= 1'b0;
      rx_win_q <= 1'b0;
      rx_cnt <= 4'h0;
   end else begin
      osc_run <= ctrl[`NRT_C_OSC_EN];
      rc_run <= wut_start || (rc_run && !wut_exp);
      irq_flag_any <= |flag;
      squelch_on <= mrt_run && ctrl[`NRT_C_SQ_EN];
      if (e_fon)
         peer_on <= 1'b1;
      else if (e_foff)
         peer_on <= 1'b0;
      if (reply_start)
         reply_busy <= 1'b1;
      else if (e_eof || k_clear)
         reply_busy <= 1'b0;
      if (mrt_start || nrt_kill || (e_txend && p2p))
         rx_window <= 1'b0;
      else if (mrt_exp)
         rx_window <= 1'b1;
      if (mrt_exp && lptgt)
         lp_watch <= 1'b1;
      else if (msg_start || k_clear)
         lp_watch <= 1'b0;
      msg_start <= lp_watch && rx_s[2] && !msg_start;
      rx_win_q <= rx_window;
      if (rx_window && rx_s[2] && !rx_s[1] && rx_cnt != 4'hF)
         rx_cnt <= rx_cnt + 4'h1;
      else if (!rx_window && rx_win_q)
         rx_cnt <= 4'h0;
      if (!rx_window && rx_win_q)
         rx_capture <= rx_cnt;
   end
end
// APB slave: zero wait states, error on unmapped address.
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `NRT_OFF_CTRL: prdata <= {23'h00_0000, ctrl};
            `NRT_OFF_MRT: prdata <= {16'h0000, mrt_cfg};
            `NRT_OFF_NRT: prdata <= {16'h0000, nrt_cfg};
            `NRT_OFF_GPT: prdata <= {16'h0000, gpt_cfg};
            `NRT_OFF_WUT: prdata <= {16'h0000, wut_cfg};
            `NRT_OFF_CMD: prdata <= 32'h0000_0000;
            `NRT_OFF_EVT: prdata <= {26'h000_0000, reply_busy, peer_on, 4'h0};
            `NRT_OFF_STAT: prdata <= {26'h000_0000, rx_window, wut_run, gpt_run, nrt_run, mrt_run, osc_ok};
            `NRT_OFF_FLAG: prdata <= {28'h000_0000, flag};
            default: pslverr <= 1'b1;
         endcase
      end
   end
end
endmodule // nrt_timers

// file: dv/nrt_chk_checker.sv
// Concurrent checks on the ports of the protocol timer block.
`timescale 1ns/1ps
module nrt_chk (
   input logic pclk, // Clock.
   input logic presetn, // Reset, active low.
   input logic psel, // APB select.
   input logic penable, // APB enable.
   input logic pwrite, // APB direction.
   input logic [11:0] paddr, // APB address.
   input logic [31:0] pwdata, // APB write data.
   input logic pready, // APB ready.
   input logic pslverr, // APB error.
   input logic rx_window, // Receive window.
   input logic squelch_on, // Squelch forced on.
   input logic osc_run, // Crystal enable.
   input logic [3:0] rx_capture, // Held receiver state.
   input logic msg_start // Message start pulse.
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready stayed high past the access cycle");
   pready_access_a: assert property (psel && !penable |=> pready && psel && penable)
      else $error("no answer in the access cycle");
   slverr_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h020))
      else $error("error response does not match the address map");
   osc_follow_a: assert property ($rose(osc_run) |-> $past(psel && penable && pwrite && paddr == 12'h000 && pwdata[0], 2))
      else $error("oscillator started without an enable write");
   squelch_window_a: assert property (squelch_on |-> !rx_window)
      else $error("window open while squelch forced");
   // The capture lands one edge after the window fell, so look two samples back for the fall.
   capture_hold_a: assert property ($changed(rx_capture) |-> $past(rx_window, 2) && !$past(rx_window))
      else $error("receiver state changed outside window close");
   msg_pulse_a: assert property (msg_start |=> !msg_start)
      else $error("message start longer than one cycle");
   window_osc_a: assert property ($rose(rx_window) |-> osc_run)
      else $error("window opened with oscillator stopped");
endmodule // nrt_chk

// file: dv/nrt_front.sv
// Front-end model: crystal and RC clocks and receiver output seen by the timers.
`timescale 1ns/1ps
module nrt_front (
   input wire osc_run, // Crystal enable.
   input wire rc_run, // RC enable.
   input wire rx_drv, // Receiver level asked by the bench.
   output reg fc_clk_in, // Carrier clock.
   output reg rc_clk_in, // RC clock.
   output wire rx_data_in // Receiver output.
);
   initial fc_clk_in = 1'b0;
   initial rc_clk_in = 1'b0;
   // Both clocks stand still while their oscillator is off, so no stray tick can reach a timer.
   always #20 fc_clk_in = osc_run ? ~fc_clk_in : 1'b0;
   always #33 rc_clk_in = rc_run ? ~rc_clk_in : 1'b0;
   assign rx_data_in = rx_drv;
endmodule // nrt_front

// file: dv/nrt_tb.sv
// Self-checking bench for the protocol timer block.
`timescale 1ns/1ps
`include "nrt_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module nfc_reader_protocol_timers_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_drv = 1'b0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, fc_clk_in, rc_clk_in, rx_data_in, rx_window, squelch_on, osc_run, rc_run, irq_flag_any, msg_start;
   logic [3:0] rx_capture;
   logic [15:0] mc, nc;
   int miscompares = 0, total_checks = 0, cyc = 0, n, msg_cnt = 0;
   nrt_timers DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fc_clk_in(fc_clk_in),
      .rc_clk_in(rc_clk_in), .rx_data_in(rx_data_in), .rx_window(rx_window), .squelch_on(squelch_on),
      .osc_run(osc_run), .rc_run(rc_run), .irq_flag_any(irq_flag_any), .rx_capture(rx_capture), .msg_start(msg_start));
   nrt_front u_front (.osc_run(osc_run), .rc_run(rc_run), .rx_drv(rx_drv), .fc_clk_in(fc_clk_in),
      .rc_clk_in(rc_clk_in), .rx_data_in(rx_data_in));
   always #5 pclk = ~pclk;
   // The message start is a one-cycle pulse, so it is counted here rather than sampled by a task.
   always @(posedge pclk) if (msg_start === 1'b1) msg_cnt++;
   task automatic conclude();
      if (miscompares == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Polls status until one bit reaches a level; the poll count keeps a dead timer from hanging the run.
   task automatic waitb(input int b, input logic v);
      n = 0;
      do begin
         apb(1'b0, `NRT_OFF_STAT, '0);
         n++;
      end while (rd[b] !== v && n < 4000);
      if (rd[b] !== v) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, rd[b], v);
      end
      // Outputs launched by the expiry settle a couple of edges after the status bit moves.
      repeat (2) @(posedge pclk);
   endtask
   function automatic logic [31:0] ctl(input logic emv, input logic p2p, input logic wm, input logic [1:0] trg);
      return {23'h0, trg, wm, 1'b0, p2p, 1'b1, emv, 1'b0, 1'b1};
   endfunction
   initial begin
      n = $urandom(32'h40ec_1578);
      mc = 16'h0001 + 16'($urandom % 2);
      nc = mc + 16'h0003;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `NRT_OFF_CTRL, '0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b0, 12'h024, '0);
      `CHK(err, 1'b1)
      apb(1'b1, `NRT_OFF_MRT, {16'h0, mc});
      apb(1'b1, `NRT_OFF_NRT, {16'h0, nc});
      apb(1'b1, `NRT_OFF_GPT, 32'h0000_0005);
      apb(1'b1, `NRT_OFF_WUT, 32'h0000_0003);
      apb(1'b0, `NRT_OFF_NRT, '0);
      `CHK(rd[15:0], nc)
      apb(1'b1, `NRT_OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, `NRT_GTRG_SOF));
      waitb(`NRT_S_OSC_OK, 1'b1);
      `CHK(rd[`NRT_S_OSC_OK], 1'b1)
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[3:0], 4'h1)
      `CHK(irq_flag_any, 1'b1)
      apb(1'b1, `NRT_OFF_FLAG, 32'h0000_000F);
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0001);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[2:1], 2'h3)
      `CHK({rx_window, squelch_on}, 2'b01)
      waitb(`NRT_S_MRT_RUN, 1'b0);
      `CHK(rx_window, 1'b1)
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[3:0], 4'h0)
      repeat (3) begin
         rx_drv <= 1'b1;
         repeat (10) @(posedge pclk);
         rx_drv <= 1'b0;
         repeat (10) @(posedge pclk);
      end
      waitb(`NRT_S_NRT_RUN, 1'b0);
      `CHK(rx_window, 1'b0)
      `CHK(rx_capture, 4'h3)
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[3:0], 4'h2)
      apb(1'b1, `NRT_OFF_FLAG, 32'h0000_000F);
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0001);
      waitb(`NRT_S_MRT_RUN, 1'b0);
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0002);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[3:2], 2'b10)
      waitb(`NRT_S_GPT_RUN, 1'b0);
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[3:0], 4'h4)
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_000C);
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_000C);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[3:2], 2'b11)
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0001);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[3:1], 3'h0)
      apb(1'b1, `NRT_OFF_FLAG, 32'h0000_000F);
      apb(1'b1, `NRT_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, `NRT_GTRG_NONE));
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0001);
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0001);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[2:1], 2'b10)
      waitb(`NRT_S_NRT_RUN, 1'b0);
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[1], 1'b1)
      apb(1'b1, `NRT_OFF_FLAG, 32'h0000_000F);
      apb(1'b1, `NRT_OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, `NRT_GTRG_NONE));
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0001);
      waitb(`NRT_S_NRT_RUN, 1'b0);
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[1], 1'b1)
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0004);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[2], 1'b0)
      apb(1'b1, `NRT_OFF_EVT, 32'h0000_0008);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[1], 1'b1)
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0001);
      apb(1'b1, `NRT_OFF_FLAG, 32'h0000_000F);
      apb(1'b1, `NRT_OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, `NRT_GTRG_NONE));
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0010);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rc_run, 1'b0)
      apb(1'b1, `NRT_OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, `NRT_GTRG_NONE));
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0010);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rc_run, 1'b1)
      waitb(`NRT_S_WUT_RUN, 1'b0);
      apb(1'b0, `NRT_OFF_FLAG, '0);
      `CHK(rd[3:0], 4'h8)
      apb(1'b1, `NRT_OFF_CTRL, 32'h0000_0029);
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0002);
      repeat (600) @(posedge pclk);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[1], 1'b1)
      waitb(`NRT_S_MRT_RUN, 1'b0);
      `CHK(msg_cnt, 0)
      rx_drv <= 1'b1;
      repeat (8) @(posedge pclk);
      rx_drv <= 1'b0;
      `CHK(msg_cnt, 1)
      apb(1'b1, `NRT_OFF_CTRL, 32'h0000_0003);
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0004);
      repeat (1500) @(posedge pclk);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[2], 1'b1)
      apb(1'b1, `NRT_OFF_CMD, 32'h0000_0001);
      apb(1'b0, `NRT_OFF_STAT, '0);
      `CHK(rd[2], 1'b0)
      conclude();
   end
endmodule // nfc_reader_protocol_timers_test
bind nrt_timers nrt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .rx_window(rx_window),
   .squelch_on(squelch_on), .osc_run(osc_run), .rx_capture(rx_capture), .msg_start(msg_start));
